// ==== rtl/tms_scan.sv ====
// Purpose: Two-clock touch matrix scanner with debounce and key encoder.
// Assumes: cmp_above is the comparator result of each sense input.
// Notes: Each clk_en cycle is one oscillator period.
//
// Summary of operation
// RULE_01: Scan two scan clocks by 16 inputs, 32 switches.
// RULE_02: Switch k on clock A and k+16 on clock B share input k.
// RULE_03: Clock B burst of 16 pulses follows clock A burst with no gap.
// RULE_04: Both clocks low one burst time after B, then A restarts.
// RULE_05: Reduced variant uses 7 inputs, 14 switches, same sequencing.
// RULE_06: Clock A burst takes 48 periods, then 96 until next burst.
// RULE_07: Clock B scans during the first 48 of those 96 periods.
// RULE_08: A complete scan lasts 144 oscillator periods.
// RULE_09: Every 23 scans a load strobe shifts latest results in.
// RULE_10: Load moves bit one into bit two, sample into bit one.
// RULE_11: Output goes touched only when both bits hold one.
// RULE_12: Touch to output change takes 3312 to 6624 periods.
// RULE_13: Release is debounced the same way with two untouched samples.
// RULE_14: Touched means pulse amplitude below the reference level.
// RULE_15: Pulse is high two periods, low one, three per pulse.
// RULE_16: Pulse n reads input n; other inputs stay grounded.
// RULE_17: Outputs are a binary switch code, not one line each.
// RULE_18: All timing comes from counters on the one oscillator clock.
`timescale 1ns/1ps
`include "tms_params.svh"
module tms_scan
	import tms_pkg::*;
#(
	parameter int NUM_INPUTS = 16
) (
	// Clock, reset and oscillator enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Panel side
	input wire logic [NUM_INPUTS-1:0] cmp_above,
	output logic scan_clock_a,
	output logic scan_clock_b,
	output logic [NUM_INPUTS-1:0] sense_gnd_out,
	output logic [NUM_INPUTS-1:0] sense_gnd_oe_n,
	// Encoded key output
	output logic [5:0] key_code,
	output logic key_valid,
	output logic load_strobe
);
	localparam int NUM_SW = 2 * NUM_INPUTS;

	generate
		if (NUM_INPUTS != 16 && NUM_INPUTS != 7) begin : g_chk
			$error("tms_scan: NUM_INPUTS must be 16 or 7"); // RULE_05
		end
	endgenerate

	// ------------------------------------------------------------------
	// Reset release and input synchronisers.
	// ------------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_sync_n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_ff[1];

	logic [NUM_INPUTS-1:0] cmp_meta_ff;
	logic [NUM_INPUTS-1:0] cmp_sync_ff;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cmp_meta_ff <= '0;
			cmp_sync_ff <= '0;
		end else if (clk_en) begin
			cmp_meta_ff <= cmp_above;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// ------------------------------------------------------------------
	// Scan sequencer.
	// ------------------------------------------------------------------
	tms_phase_t phase_ff, nxt_phase;
	logic [1:0] sub_ff, nxt_sub;
	logic [3:0] pulse_ff, nxt_pulse;
	logic [4:0] scan_cnt_ff;
	logic pulse_end, burst_end, scan_end;

	assign pulse_end = (sub_ff == `TMS_SUB_LAST);
	assign burst_end = pulse_end && (pulse_ff == `TMS_PULSE_LAST);
	assign scan_end = burst_end && (phase_ff == PH_IDLE);

	always_comb begin
		nxt_sub = pulse_end ? `TMS_SUB_FIRST : sub_ff + 2'h1; // RULE_15
		nxt_pulse = pulse_end ? pulse_ff + 4'h1 : pulse_ff;
		nxt_phase = phase_ff;
		if (burst_end) begin
			unique case (phase_ff)
				PH_A: nxt_phase = PH_B; // RULE_03
				PH_B: nxt_phase = PH_IDLE; // RULE_04
				PH_IDLE: nxt_phase = PH_A;
				default: nxt_phase = PH_A;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			phase_ff <= PH_A;
			sub_ff <= `TMS_SUB_FIRST;
			pulse_ff <= `TMS_PULSE_FIRST;
		end else if (clk_en) begin
			phase_ff <= nxt_phase; // RULE_18
			sub_ff <= nxt_sub;
			pulse_ff <= nxt_pulse;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			scan_cnt_ff <= 5'h0;
		end else if (clk_en && scan_end) begin
			if (scan_cnt_ff == `TMS_SCAN_CNT_LAST) begin
				scan_cnt_ff <= 5'h0; // RULE_09
			end else begin
				scan_cnt_ff <= scan_cnt_ff + 5'h1;
			end
		end
	end
	assign load_strobe = scan_end && (scan_cnt_ff == `TMS_SCAN_CNT_LAST);

	// ------------------------------------------------------------------
	// Registered pin drive, decoded from the next sequencer state.
	// ------------------------------------------------------------------
	logic nxt_high;
	assign nxt_high = (nxt_sub != `TMS_SUB_LAST);
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			scan_clock_a <= 1'b0;
			scan_clock_b <= 1'b0;
		end else if (clk_en) begin
			scan_clock_a <= nxt_high && (nxt_phase == PH_A); // RULE_06
			scan_clock_b <= nxt_high && (nxt_phase == PH_B); // RULE_07
		end
	end

	// Latest scan result per switch; the sample taken in the low period
	// sees, through the two synchroniser stages, the first high period.
	logic [NUM_SW-1:0] latest_ff;
	genvar i;
	generate
		for (i = 0; i < NUM_INPUTS; i++) begin : g_in
			logic sel_nxt;
			assign sel_nxt = (nxt_phase != PH_IDLE) &&
				(nxt_pulse == 4'(i));
			always_ff @(posedge sys_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					sense_gnd_oe_n[i] <= 1'b0;
				end else if (clk_en) begin
					sense_gnd_oe_n[i] <= sel_nxt; // RULE_16
				end
			end
			assign sense_gnd_out[i] = 1'b0;
			always_ff @(posedge sys_clk or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					latest_ff[i] <= 1'b0;
					latest_ff[i+NUM_INPUTS] <= 1'b0;
				end else if (clk_en && pulse_end && pulse_ff == 4'(i)) begin
					if (phase_ff == PH_A) begin
						latest_ff[i] <= !cmp_sync_ff[i]; // RULE_14
					end
					if (phase_ff == PH_B) begin
						latest_ff[i+NUM_INPUTS] <= !cmp_sync_ff[i]; // RULE_02
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Debounce and encoder.
	// ------------------------------------------------------------------
	logic [NUM_SW-1:0] sw_state;
	tms_debounce #(.NUM_SW(NUM_SW)) u_deb (
		.clk(sys_clk),
		.rst_n(rst_sync_n),
		.clk_en(clk_en),
		.load(load_strobe),
		.sample(latest_ff),
		.state(sw_state)
	); // RULE_01 RULE_12

	logic [5:0] nxt_code;
	always_comb begin
		nxt_code = 6'h0;
		for (int k = NUM_SW - 1; k >= 0; k--) begin
			if (sw_state[k]) begin
				nxt_code = 6'(k + 1);
			end
		end
	end
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			key_code <= 6'h0;
			key_valid <= 1'b0;
		end else if (clk_en) begin
			key_code <= nxt_code; // RULE_17
			key_valid <= |sw_state;
		end
	end

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	logic [7:0] per_ff;
	logic [11:0] ld_per_ff;
	logic scan_start;
	assign scan_start = clk_en && phase_ff == PH_A &&
		pulse_ff == `TMS_PULSE_FIRST && sub_ff == `TMS_SUB_FIRST;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			per_ff <= `TMS_SCAN_LEN_CNT;
			ld_per_ff <= 12'h0;
		end else if (clk_en) begin
			per_ff <= scan_start ? 8'h1 : per_ff + 8'h1;
			ld_per_ff <= load_strobe ? 12'h0 : ld_per_ff + 12'h1;
		end
	end

	a_clock_exclusive: assert property (@(posedge sys_clk) // RULE_03
		disable iff (!rst_sync_n) !(scan_clock_a && scan_clock_b))
		else $error("scan clocks high together");
	a_b_follows_a: assert property (@(posedge sys_clk) // RULE_03
		disable iff (!rst_sync_n)
		(clk_en && phase_ff == PH_A && burst_end) |=>
		(phase_ff == PH_B && scan_clock_b))
		else $error("clock B burst did not follow clock A");
	a_idle_low: assert property (@(posedge sys_clk) // RULE_04
		disable iff (!rst_sync_n)
		(phase_ff == PH_IDLE) |-> (!scan_clock_a && !scan_clock_b))
		else $error("scan clock high during idle");
	a_scan_period: assert property (@(posedge sys_clk) // RULE_08
		disable iff (!rst_sync_n)
		scan_start |-> per_ff == `TMS_SCAN_LEN_CNT)
		else $error("scan period not 144");
	a_burst_length: assert property (@(posedge sys_clk) // RULE_06
		disable iff (!rst_sync_n)
		(clk_en && phase_ff == PH_B && pulse_ff == `TMS_PULSE_FIRST &&
		sub_ff == `TMS_SUB_FIRST) |-> per_ff == `TMS_BURST_AT)
		else $error("clock A burst not 48 periods");
	a_load_spacing: assert property (@(posedge sys_clk) // RULE_09
		disable iff (!rst_sync_n)
		(clk_en && load_strobe) |-> ld_per_ff == `TMS_LOAD_LAST_PERIOD)
		else $error("load strobe spacing not 3312");
	a_ground_idle: assert property (@(posedge sys_clk) // RULE_16
		disable iff (!rst_sync_n)
		(clk_en && phase_ff == PH_IDLE && sub_ff == `TMS_SUB_FIRST &&
		pulse_ff != `TMS_PULSE_FIRST) |-> sense_gnd_oe_n == '0)
		else $error("sense input released during idle");
	a_debounce_hold: assert property (@(posedge sys_clk) // RULE_11
		disable iff (!rst_sync_n)
		(sw_state != $past(sw_state)) |-> $past(load_strobe && clk_en))
		else $error("switch state changed without load");
	a_code_valid: assert property (@(posedge sys_clk) // RULE_17
		disable iff (!rst_sync_n)
		$past(clk_en) |-> (key_valid == $past(|sw_state) &&
		key_valid == (key_code != 6'h0)))
		else $error("key code does not match switch state");
endmodule

// ==== rtl/tms_params.svh ====
// Purpose: Timing counts and field values of the touch matrix scanner.
// Assumes: One enabled sys_clk cycle equals one oscillator period.
// Notes: Definitions only.
`ifndef TMS_PARAMS_SVH
`define TMS_PARAMS_SVH

// --------------------------------------------------------------------
// Pulse shape and burst.
// --------------------------------------------------------------------
`define TMS_PULSES 16
`define TMS_SUB_LAST 2'h2
`define TMS_SUB_FIRST 2'h0
`define TMS_PULSE_LAST 4'hF
`define TMS_PULSE_FIRST 4'h0

// --------------------------------------------------------------------
// Scan and load periods, in oscillator periods.
// --------------------------------------------------------------------
`define TMS_BURST_PERIODS 48
`define TMS_SCAN_PERIODS 144
`define TMS_SCANS_PER_LOAD 23
`define TMS_LOAD_PERIODS (`TMS_SCAN_PERIODS * `TMS_SCANS_PER_LOAD)
`define TMS_BURST_AT 8'h30
`define TMS_SCAN_LEN_CNT 8'h90
`define TMS_SCAN_CNT_LAST 5'h16
`define TMS_LOAD_LAST_PERIOD 12'hCEF

`endif

// ==== rtl/tms_pkg.sv ====
// Purpose: Types shared by the touch matrix scanner.
// Assumes: Nothing.
// Notes: Constants live in tms_params.svh.
package tms_pkg;
	typedef enum logic [1:0] {PH_A, PH_B, PH_IDLE} tms_phase_t;
endpackage

// ==== rtl/tms_debounce.sv ====
// Purpose: Two-bit shift debounce for every matrix switch.
// Assumes: Load arrives once per 23 scans.
// Notes: Output follows only two equal successive samples.
`timescale 1ns/1ps
module tms_debounce
	import tms_pkg::*;
#(
	parameter int NUM_SW = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Samples and strobe
	input wire logic load,
	input wire logic [NUM_SW-1:0] sample,
	// Debounced state
	output logic [NUM_SW-1:0] state
);

	generate
		if (NUM_SW < 1) begin : g_chk
			$error("tms_debounce: NUM_SW must be positive");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < NUM_SW; i++) begin : g_sw
			logic [1:0] shift_ff;
			logic state_ff;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					shift_ff <= 2'h0;
				end else if (clk_en && load) begin
					shift_ff <= {shift_ff[0], sample[i]}; // RULE_10
				end
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					state_ff <= 1'b0;
				end else if (clk_en && load) begin
					if (shift_ff[0] && sample[i]) begin
						state_ff <= 1'b1; // RULE_11
					end else if (!shift_ff[0] && !sample[i]) begin
						state_ff <= 1'b0; // RULE_13
					end
				end
			end
			assign state[i] = state_ff;
		end
	endgenerate
endmodule

// ==== test/tms_panel_model.sv ====
// Purpose: Passive touch panel behind the two scan clocks.
// Assumes: Untouched pads exceed the reference, touched ones do not.
// Notes: A grounded input shows no pulse and reads below reference.
`timescale 1ns/1ps
module tms_panel_model #(
	parameter int N = 16
) (
	// Scan side
	input wire logic scan_clock_a,
	input wire logic scan_clock_b,
	input wire logic [N-1:0] sense_gnd_oe_n,
	// Finger state, switch k+1 at bit k
	input wire logic [2*N-1:0] touched,
	// Comparator results
	output logic [N-1:0] cmp_above
);
	always_comb begin
		for (int i = 0; i < N; i++) begin
			cmp_above[i] = sense_gnd_oe_n[i] &
				((scan_clock_a & ~touched[i]) |
				(scan_clock_b & ~touched[i+N]));
		end
	end
endmodule

// ==== test/test_touch_matrix_scan_debounce.sv ====
// Purpose: Self-checking bench of the touch matrix scanner.
// Assumes: One clock per oscillator period while clk_en is high.
// Notes: The panel model supplies the comparator results.
`timescale 1ns/1ps
`include "tms_params.svh"
module test_touch_matrix_scan_debounce;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [31:0] touched = 32'h0;
	logic [15:0] cmp_above;
	logic [15:0] oe_n;
	logic [15:0] gnd_out;
	logic sc_a;
	logic sc_b;
	logic key_valid;
	logic load_strobe;
	logic [5:0] key_code;
	int bad_count = 0;
	int tests_run = 0;

	always #2.5 sys_clk = ~sys_clk;

	tms_scan #(.NUM_INPUTS(16)) i_tms_scan (.sys_clk(sys_clk),
		.rst_n(rst_n), .clk_en(clk_en), .cmp_above(cmp_above),
		.scan_clock_a(sc_a), .scan_clock_b(sc_b),
		.sense_gnd_out(gnd_out), .sense_gnd_oe_n(oe_n),
		.key_code(key_code), .key_valid(key_valid),
		.load_strobe(load_strobe));

	tms_panel_model #(.N(16)) i_tms_panel_model (.scan_clock_a(sc_a),
		.scan_clock_b(sc_b), .sense_gnd_oe_n(oe_n),
		.touched(touched), .cmp_above(cmp_above));

	// --------------------------------------------------------------
	// Shared tasks.
	// --------------------------------------------------------------
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wait_load(output int n);
		n = 0;
		do begin
			step();
			n++;
			if (n > 4000) begin
				check("load_timeout", 1'b0, 1'b1);
				stop_test();
			end
		end while (load_strobe !== 1'b1);
	endtask

	// --------------------------------------------------------------
	// Scenarios.
	// --------------------------------------------------------------
	task automatic scan_shape();
		int lo;
		int p;
		logic [15:0] exp_oe;
		lo = 0;
		for (int n = 0; n < 400 && !(sc_a === 1'b1 && lo >= 40); n++) begin
			lo = (sc_a === 1'b0 && sc_b === 1'b0) ? lo + 1 : 0;
			step();
		end
		for (int c = 0; c < 288; c++) begin
			p = c % 144;
			exp_oe = 16'h0;
			if (p < 96)
				exp_oe[(p % 48) / 3] = 1'b1;
			check("scan_clock_a", sc_a, p < 48 && p % 3 != 2);
			check("scan_clock_b", sc_b, p >= 48 && p < 96 && p % 3 != 2);
			check("sense_release", oe_n, exp_oe);
			check("sense_drive", gnd_out, 16'h0);
			if (load_strobe === 1'b1)
				check("load_phase", p, 143);
			step();
		end
	endtask

	task automatic load_period();
		int n;
		wait_load(n);
		wait_load(n);
		check("load_period", n, `TMS_LOAD_PERIODS);
		step();
		check("load_width", load_strobe, 1'b0);
	endtask

	task automatic freeze();
		logic a;
		logic [15:0] o;
		clk_en = 1'b0;
		a = sc_a;
		o = oe_n;
		repeat (6) step();
		check("freeze_clock", sc_a, a);
		check("freeze_sense", oe_n, o);
		clk_en = 1'b1;
	endtask

	task automatic single_sample();
		int n;
		logic hit;
		hit = 1'b0;
		wait_load(n);
		touched = 32'h0000_0004;
		wait_load(n);
		touched = 32'h0;
		for (int k = 0; k < 7000; k++) begin
			step();
			hit = hit | key_valid;
		end
		check("single_sample", hit, 1'b0);
	endtask

	task automatic debounce_case(input logic [31:0] t,
		input logic [5:0] code, input logic v);
		int n;
		touched = t;
		n = 0;
		while (key_code !== code && n < 7000) begin
			step();
			n++;
		end
		check("debounce_min", n >= 3312, 1'b1);
		check("debounce_max", n <= 6632, 1'b1);
		check("key_code", key_code, code);
		check("key_valid", key_valid, v);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		scan_shape();
		load_period();
		freeze();
		single_sample();
		debounce_case(32'h0001_0010, 6'h05, 1'b1);
		debounce_case(32'h0001_0000, 6'h11, 1'b1);
		debounce_case(32'h0, 6'h00, 1'b0);
		debounce_case(32'h8000_0000, 6'h20, 1'b1);
		debounce_case(32'h0, 6'h00, 1'b0);
		stop_test();
	end
endmodule
